//--- rtl/irq_claim_pkg.sv
// How it works
// - six enable words form one bit array
// - enable bit zero always reads zero
// - enable words writable per byte under the write strobes
// - sixth word bits 31:26 reserved, read zero
// - three-bit threshold, all values up to seven
// - priority at or below threshold is masked
// - claim read returns best pending id or zero
// - nonzero claim clears that pending bit atomically
// - claim reads served at any time
// - claim selection ignores the threshold
// - completion id never compared to last claim
// - completion for a disabled source is ignored
// - claim register 32 bits, read claims, write completes
// - priority three bits, zero never interrupts
// - equal priority goes to smallest id
// - pending bit n in word n/32, bit n%32
package irq_claim_pkg;

    localparam int             N_SRC          = 186;
    localparam int             ID_W           = 8;
    localparam int             PRIO_W         = 3;
    localparam int             N_WORDS        = 6;
    localparam int             WORD_W         = 32;
    localparam int             ADDR_W         = 32;
    localparam int             BYTE_W         = 8;
    localparam int             N_BYTES        = 4;
    localparam logic [31:0]    ENABLE_BASE    = 32'h0c002000;
    localparam logic [31:0]    ENABLE_SIXTH   = 32'h0c00201c;
    localparam logic [31:0]    PENDING_BASE   = 32'h0c001000;
    localparam logic [31:0]    THRESHOLD_ADDR = 32'h0c200000;
    localparam logic [31:0]    CLAIM_ADDR     = 32'h0c200004;
    localparam logic [31:0]    WORD_STRIDE    = 32'h00000004;
    localparam logic [2:0]     NO_WORD        = 3'h7;
    localparam logic [2:0]     SIXTH_WORD     = 3'h5;
    localparam logic [2:0]     THR_RESET      = 3'h0;
    localparam logic [2:0]     PRIO_NEVER     = 3'h0;
    localparam logic [1:0]     RESP_OKAY      = 2'h0;
    localparam logic [1:0]     RESP_SLVERR    = 2'h2;
    localparam logic [7:0]     NO_IRQ         = 8'h00;
    localparam int             SIXTH_RESV_LSB = 26;

endpackage : irq_claim_pkg

//--- rtl/irq_core_if.sv
`timescale 1ns/1ps
interface irq_core_if
    import irq_claim_pkg::*;
#(
    parameter int N = N_SRC
);
    logic [N:0]          pending;
    logic [N:0]          enable;
    logic [N*PRIO_W-1:0] prio;
    logic                claim;
    logic [ID_W-1:0]     claim_id;
    logic                complete;
    logic [ID_W-1:0]     complete_id;
    logic [ID_W-1:0]     best_id;
    logic [PRIO_W-1:0]   best_prio;

    modport gateway (input claim, claim_id, complete, complete_id, output pending);
    modport arbiter (input pending, enable, prio, output best_id, best_prio);
    modport ctrl    (output claim, claim_id, complete, complete_id, enable, prio,
                     input pending, best_id, best_prio);
endinterface : irq_core_if

//--- rtl/irq_gateway.sv
`timescale 1ns/1ps
module irq_gateway
    import irq_claim_pkg::*;
#(
    parameter int N = N_SRC
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // level sources
    input  wire logic [N-1:0] irq_src,
    // core side
    irq_core_if.gateway       gw
);
    typedef struct packed {
        logic [N:0] sync1;
        logic [N:0] sync2;
        logic [N:0] pending;
        logic [N:0] busy;
    } gw_state_s;

    gw_state_s  state;
    gw_state_s  next_state;
    logic [N:0] clr_mask;
    logic [N:0] cmp_mask;

    function automatic logic [N:0] id_mask(input logic [ID_W-1:0] id);
        id_mask = {{N{1'b0}}, 1'b1} << id;
    endfunction : id_mask

    assign clr_mask   = gw.claim    ? id_mask(gw.claim_id)    : '0;
    assign cmp_mask   = gw.complete ? id_mask(gw.complete_id) : '0;
    assign gw.pending = state.pending;

    always_comb begin
        next_state       = state;
        next_state.sync1 = {irq_src, 1'b0};
        next_state.sync2 = state.sync1;
        // claim sets busy even if a completion clears it in the same cycle
        next_state.busy  = (state.busy & ~cmp_mask) | clr_mask;
        next_state.pending = (state.pending & ~clr_mask)
                           | (state.sync2 & ~state.busy & ~clr_mask);
        next_state.pending[0] = 1'b0;
        next_state.busy[0]    = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : irq_gateway

//--- rtl/irq_arbiter.sv
`timescale 1ns/1ps
module irq_arbiter
    import irq_claim_pkg::*;
#(
    parameter int N = N_SRC
) (
    // core side
    irq_core_if.arbiter arb
);
    logic [PRIO_W-1:0] cand;

    // downward scan with >= lets the lowest id win a tie
    always_comb begin
        cand          = PRIO_NEVER;
        arb.best_id   = NO_IRQ;
        arb.best_prio = PRIO_NEVER;
        for (int i = N; i >= 1; i--) begin
            cand = arb.prio[(i-1)*PRIO_W +: PRIO_W];
            if (arb.pending[i] && arb.enable[i] && cand != PRIO_NEVER
                && cand >= arb.best_prio) begin
                arb.best_id   = ID_W'(i);
                arb.best_prio = cand;
            end
        end
    end

endmodule : irq_arbiter

//--- rtl/platform_irq_enable_claim.sv
`timescale 1ns/1ps
module platform_irq_enable_claim
    import irq_claim_pkg::*;
#(
    parameter int N = N_SRC
) (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // write address
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    // write data
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire logic [WORD_W-1:0]   s_axi_wdata,
    input  wire logic [N_BYTES-1:0]  s_axi_wstrb,
    // write response
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    // read address
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    // read data
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output logic [WORD_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    // interrupt sources and their priorities
    input  wire logic [N-1:0]        irq_src,
    input  wire logic [N*PRIO_W-1:0] src_priority,
    // request to the core
    output logic                     ext_irq_req
);
    localparam int FLAT_W = N_WORDS * WORD_W;

    typedef struct packed {
        logic                aw_full;
        logic [ADDR_W-1:0]   aw_addr;
        logic                w_full;
        logic [WORD_W-1:0]   w_data;
        logic [N_BYTES-1:0]  w_strb;
        logic                b_valid;
        logic [1:0]          b_resp;
        logic                r_valid;
        logic [WORD_W-1:0]   r_data;
        logic [1:0]          r_resp;
        logic [FLAT_W-1:0]   enable;
        logic [PRIO_W-1:0]   threshold;
        logic                ext_irq;
    } ctl_state_s;

    ctl_state_s         state;
    ctl_state_s         next_state;
    logic               write_go;
    logic               read_go;
    logic [2:0]         wr_word;
    logic [2:0]         rd_word;
    logic [2:0]         rd_pword;
    logic [WORD_W-1:0]  wr_mask;
    logic [FLAT_W-1:0]  pend_flat;
    logic [ID_W-1:0]    done_id;

    irq_core_if #(.N(N)) core ();

    irq_gateway #(.N(N)) u_gateway (
        .aclk    (aclk),
        .aresetn (aresetn),
        .irq_src (irq_src),
        .gw      (core.gateway)
    );

    irq_arbiter #(.N(N)) u_arbiter (
        .arb (core.arbiter)
    );

    // enable word index of an address, each word its own 32-bit slot
    function automatic logic [2:0] enable_word(input logic [ADDR_W-1:0] addr);
        enable_word = NO_WORD;
        if (addr == ENABLE_SIXTH) begin
            enable_word = SIXTH_WORD;
        end else begin
            for (int k = 0; k < int'(SIXTH_WORD); k++) begin
                if (addr == ENABLE_BASE + WORD_STRIDE * 32'(k)) begin
                    enable_word = 3'(k);
                end
            end
        end
    endfunction : enable_word

    // pending word index of an address
    function automatic logic [2:0] pending_word(input logic [ADDR_W-1:0] addr);
        pending_word = NO_WORD;
        for (int k = 0; k < N_WORDS; k++) begin
            if (addr == PENDING_BASE + WORD_STRIDE * 32'(k)) begin
                pending_word = 3'(k);
            end
        end
    endfunction : pending_word

    // writable bits of one enable word: ids 1 to N, sixth word top reserved
    function automatic logic [WORD_W-1:0] word_mask(input logic [2:0] k);
        int idx;
        word_mask = '0;
        for (int b = 0; b < WORD_W; b++) begin
            idx = int'(k) * WORD_W + b;
            // sixth word stops at bit 25, so the last id has no enable bit
            word_mask[b] = (idx >= 1) && (idx <= N)
                           && !(k == SIXTH_WORD && b >= SIXTH_RESV_LSB);
        end
    endfunction : word_mask

    assign write_go  = state.aw_full && state.w_full && !state.b_valid;
    assign read_go   = s_axi_arvalid && !state.r_valid;
    assign wr_word   = enable_word(state.aw_addr);
    assign rd_word   = enable_word(s_axi_araddr);
    assign rd_pword  = pending_word(s_axi_araddr);
    assign wr_mask   = word_mask(wr_word);
    assign pend_flat = FLAT_W'(core.pending);
    assign done_id   = state.w_data[ID_W-1:0];

    // handshakes
    assign s_axi_awready = !state.aw_full && !state.b_valid;
    assign s_axi_wready  = !state.w_full && !state.b_valid;
    assign s_axi_arready = !state.r_valid;
    assign s_axi_bvalid  = state.b_valid;
    assign s_axi_bresp   = state.b_resp;
    assign s_axi_rvalid  = state.r_valid;
    assign s_axi_rdata   = state.r_data;
    assign s_axi_rresp   = state.r_resp;
    assign ext_irq_req   = state.ext_irq;

    // claim on a read of the claim register with something to hand out
    assign core.claim    = read_go && s_axi_araddr == CLAIM_ADDR
                           && core.best_id != NO_IRQ;
    assign core.claim_id = core.best_id;

    // any id up to N written is a completion unless its source is disabled
    assign core.complete = write_go && state.aw_addr == CLAIM_ADDR
                           && |state.w_strb
                           && int'(done_id) <= N
                           && state.enable[done_id];
    assign core.complete_id = done_id;
    assign core.enable      = state.enable[N:0];
    assign core.prio        = src_priority;

    always_comb begin
        next_state = state;

        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_full = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_full = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end

        if (write_go) begin
            next_state.aw_full = 1'b0;
            next_state.w_full  = 1'b0;
            next_state.b_valid = 1'b1;
            next_state.b_resp  = RESP_OKAY;
            if (wr_word != NO_WORD) begin
                for (int b = 0; b < N_BYTES; b++) begin
                    if (state.w_strb[b]) begin
                        next_state.enable[int'(wr_word) * WORD_W + b * BYTE_W +: BYTE_W] =
                            state.w_data[b * BYTE_W +: BYTE_W]
                            & wr_mask[b * BYTE_W +: BYTE_W];
                    end
                end
            end else if (state.aw_addr == THRESHOLD_ADDR) begin
                if (state.w_strb[0]) begin
                    next_state.threshold = state.w_data[PRIO_W-1:0];
                end
            end else if (state.aw_addr == CLAIM_ADDR) begin
                next_state.b_resp = RESP_OKAY;
            end else if (pending_word(state.aw_addr) != NO_WORD) begin
                next_state.b_resp = RESP_OKAY;
            end else begin
                next_state.b_resp = RESP_SLVERR;
            end
        end else if (state.b_valid && s_axi_bready) begin
            next_state.b_valid = 1'b0;
        end

        if (read_go) begin
            next_state.r_valid = 1'b1;
            next_state.r_resp  = RESP_OKAY;
            if (rd_word != NO_WORD) begin
                next_state.r_data = state.enable[int'(rd_word) * WORD_W +: WORD_W];
            end else if (rd_pword != NO_WORD) begin
                next_state.r_data = pend_flat[int'(rd_pword) * WORD_W +: WORD_W];
            end else if (s_axi_araddr == THRESHOLD_ADDR) begin
                next_state.r_data = WORD_W'(state.threshold);
            end else if (s_axi_araddr == CLAIM_ADDR) begin
                next_state.r_data = WORD_W'(core.best_id);
            end else begin
                next_state.r_data = '0;
                next_state.r_resp = RESP_SLVERR;
            end
        end else if (state.r_valid && s_axi_rready) begin
            next_state.r_valid = 1'b0;
        end

        // best enabled pending priority must beat the threshold
        next_state.ext_irq = core.best_prio > state.threshold;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state           <= '0;
            state.threshold <= THR_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule : platform_irq_enable_claim

//--- tb/platform_irq_enable_claim_props.sv
`timescale 1ns/1ps
module platform_irq_enable_claim_props
    import irq_claim_pkg::*;
#(
    parameter int N = N_SRC
) (
    // clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // register bus
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [WORD_W-1:0] s_axi_rdata,
    // request to the core
    input wire logic              ext_irq_req
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic rd_take;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    chk_b_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_r_holds:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
    chk_rd_answer:
    assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
    chk_busy_block:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response open");
    chk_rd_block:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    chk_en_bit0:
    assert property (rd_take && s_axi_araddr == ENABLE_BASE |=> s_axi_rdata[0] == 1'b0)
        else $error("enable bit zero set");
    chk_sixth_resv:
    assert property (rd_take && s_axi_araddr == ENABLE_SIXTH |=> s_axi_rdata[31:26] == 6'h00)
        else $error("reserved enable bits set");
    chk_thr_width:
    assert property (rd_take && s_axi_araddr == THRESHOLD_ADDR |=> s_axi_rdata[31:3] == '0)
        else $error("threshold upper bits set");
    chk_claim_range:
    assert property (rd_take && s_axi_araddr == CLAIM_ADDR |=> s_axi_rdata <= 32'(N))
        else $error("claim id out of range");
    cover property (rd_take && s_axi_araddr == CLAIM_ADDR);
    cover property ($rose(ext_irq_req));
    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : platform_irq_enable_claim_props

bind platform_irq_enable_claim platform_irq_enable_claim_props #(.N(N)) u_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ext_irq_req
);

//--- tb/irq_src_model.sv
`timescale 1ns/1ps
module irq_src_model
    import irq_claim_pkg::*;
(
    // clock
    input  wire logic             aclk,
    // lines the bench wants high
    input  wire logic [N_SRC-1:0] raise,
    // level lines to the block
    output logic      [N_SRC-1:0] irq_src
);
    // active-high levels, unused lines low, line 0 is id 1
    always @(posedge aclk) begin
        irq_src <= raise;
    end
endmodule : irq_src_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb
    import irq_claim_pkg::*;
;
    logic                    aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic                    s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic                    s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_irq_req;
    logic [ADDR_W-1:0]       s_axi_awaddr, s_axi_araddr;
    logic [WORD_W-1:0]       s_axi_wdata, s_axi_rdata, d, got;
    logic [N_BYTES-1:0]      s_axi_wstrb;
    logic [1:0]              s_axi_bresp, s_axi_rresp, rsp;
    logic [N_SRC-1:0]        raise, irq_src;
    logic [N_SRC*PRIO_W-1:0] src_priority;
    int                      num_errors, checked, seed, k;

    irq_src_model u_src (.aclk, .raise, .irq_src);
    platform_irq_enable_claim u_dut (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .irq_src, .src_priority, .ext_irq_req
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic cmp_data(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_data

    task automatic cmp_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_resp

    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    function automatic logic [31:0] en_addr(input int i);
        return (i == 5) ? ENABLE_SIXTH : ENABLE_BASE + 32'(4 * i);
    endfunction : en_addr

    function automatic logic [31:0] en_mask(input int i);
        return (i == 0) ? 32'hffff_fffe : ((i == 5) ? 32'h03ff_ffff : 32'hffff_ffff);
    endfunction : en_mask

    task automatic claim_is(input logic [31:0] e);
        rd(CLAIM_ADDR, got, rsp);
        cmp_data("claim id", e, got);
    endtask : claim_is

    task automatic tally_and_finish();
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        seed = 2768;
        num_errors = 0;
        checked = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        raise = '0;
        src_priority = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(THRESHOLD_ADDR, got, rsp);
        cmp_data("threshold reset", 32'h0, got);
        for (k = 0; k < 6; k++) begin
            d = $random(seed);
            wr(en_addr(k), d, rsp);
            rd(en_addr(k), got, rsp);
            cmp_data("enable word", d & en_mask(k), got);
            wr(en_addr(k), 32'h0, rsp);
        end
        wr(32'h0c002014, 32'hffff_ffff, rsp);
        cmp_resp("unmapped write", RESP_SLVERR, rsp);
        rd(32'h0c002014, got, rsp);
        cmp_resp("unmapped read", RESP_SLVERR, rsp);
        cmp_data("unmapped data", 32'h0, got);
        d = $random(seed);
        wr(THRESHOLD_ADDR, d, rsp);
        rd(THRESHOLD_ADDR, got, rsp);
        cmp_data("threshold", d & 32'h7, got);
        src_priority[2*PRIO_W +: PRIO_W] <= 3'h4;
        src_priority[4*PRIO_W +: PRIO_W] <= 3'h4;
        raise <= 186'h54;
        wr(ENABLE_BASE, 32'h0000_00a8, rsp);
        wr(THRESHOLD_ADDR, 32'h4, rsp);
        repeat (8) @(posedge aclk);
        cmp_data("request at equal", 32'h0, {31'h0, ext_irq_req});
        wr(THRESHOLD_ADDR, 32'h3, rsp);
        repeat (4) @(posedge aclk);
        cmp_data("request above", 32'h1, {31'h0, ext_irq_req});
        wr(THRESHOLD_ADDR, 32'h7, rsp);
        repeat (4) @(posedge aclk);
        cmp_data("request masked", 32'h0, {31'h0, ext_irq_req});
        claim_is(32'd3);
        claim_is(32'd5);
        claim_is(32'd0);
        rd(PENDING_BASE, got, rsp);
        cmp_data("pending word", 32'h0000_0080, got);
        wr(CLAIM_ADDR, 32'h5, rsp);
        cmp_resp("completion", RESP_OKAY, rsp);
        repeat (4) @(posedge aclk);
        claim_is(32'd5);
        wr(ENABLE_BASE, 32'h0000_00a0, rsp);
        wr(CLAIM_ADDR, 32'd3, rsp);
        wr(ENABLE_BASE, 32'h0000_00a8, rsp);
        repeat (4) @(posedge aclk);
        claim_is(32'd0);
        wr(CLAIM_ADDR, 32'd3, rsp);
        wr(CLAIM_ADDR, 32'd5, rsp);
        // id 185 sits at bit 25 of the sixth word
        src_priority[184*PRIO_W +: PRIO_W] <= 3'h6;
        raise[184] <= 1'b1;
        wr(ENABLE_SIXTH, 32'h0200_0000, rsp);
        repeat (6) @(posedge aclk);
        claim_is(32'hb9);
        claim_is(32'd3);
        tally_and_finish();
    end
endmodule : tb
